//--- logic/codec_port_pkg.sv
// constants and types of the codec direct register port
// Notes on behaviour
// - index holds five index bits plus three flags
// - legacy mode ignores top index bit
// - gate bit stops requests while interrupt set
// - gate clear: requests free, counter decrements
// - outstanding requests finish; new need zero interrupt
// - drained: dac midscale or repeat, capture holds
// - clearing interrupt or gate resumes requests
// - counter holds while gate and interrupt set
// - no overrun or underrun while suppressed
// - dac muted while mode flag set
// - 32 samples of midscale adc, muted dac
// - calibration busy 384 samples if auto-calibrate
// - top index bit read-only, shows initialization
// - index reads 40h after init, 80h during
// - window returns indexed register, 80h during init
// - interrupt flag is the only sticky bit
// - two select pins choose four direct registers
// - status write clears interrupt flag unless counter underflows that cycle
package codec_port_pkg;
    localparam logic [1:0] SEL_INDEX      = 2'h0;
    localparam logic [1:0] SEL_WINDOW     = 2'h1;
    localparam logic [1:0] SEL_STATUS     = 2'h2;
    localparam logic [1:0] SEL_PIO        = 2'h3;
    localparam logic [7:0] INDEX_RESET    = 8'h40;
    localparam logic [7:0] INIT_READ      = 8'h80;
    localparam int         IDX_INIT_BIT   = 7;
    localparam int         IDX_MODE_BIT   = 6;
    localparam int         IDX_GATE_BIT   = 5;
    localparam int         IDX_TOP_BIT    = 4;
    localparam logic [4:0] REG_LEFT_OUT   = 5'h06;
    localparam logic [4:0] REG_RIGHT_OUT  = 5'h07;
    localparam logic [4:0] REG_IFACE      = 5'h09;
    localparam logic [4:0] REG_ERRORS     = 5'h0b;
    localparam logic [4:0] REG_MISC       = 5'h0c;
    localparam logic [4:0] REG_UPPER_BASE = 5'h0e;
    localparam logic [4:0] REG_LOWER_BASE = 5'h0f;
    localparam logic [4:0] REG_FEATURE    = 5'h10;
    localparam int         MUTE_BIT       = 7;
    localparam int         PEN_BIT        = 0;
    localparam int         CEN_BIT        = 1;
    localparam int         AUTO_CALIBRATE_BIT_BIT       = 3;
    localparam int         COR_BIT        = 7;
    localparam int         PUR_BIT        = 6;
    localparam int         ACI_BIT        = 5;
    localparam int         EXPANDED_MODE_BIT      = 6;
    localparam int         ZERO_FILL_BIT  = 0;
    localparam logic [5:0] SETTLE_SAMPLES = 6'd32;
    localparam logic [8:0] CAL_SAMPLES    = 9'd384;
    localparam logic [15:0] INIT_CYCLES   = 16'd64;

    typedef enum logic [1:0] {
        ST_INIT   = 2'b00,
        ST_RUN    = 2'b01,
        ST_MODE   = 2'b11,
        ST_SETTLE = 2'b10
    } phase_t;
endpackage

//--- logic/codec_direct_register_port.sv
// direct register port with indexed window, gating and mode-change sequencing
module codec_direct_register_port #(
    parameter logic [15:0] INIT_LEN = codec_port_pkg::INIT_CYCLES
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    // host bus pins
    input  wire logic [1:0] i_direct_select_pins,
    input  wire logic       i_cs_b,
    input  wire logic       i_rd_b,
    input  wire logic       i_wr_b,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_data,
    output logic            o_data_oe,
    // dma handshake pins
    output logic            o_playback_request_out,
    output logic            o_capture_request_out,
    input  wire logic       i_playback_ack_b,
    input  wire logic       i_capture_ack_b,
    // sample engine side
    input  wire logic       i_sample_tick,
    input  wire logic       i_sample_moved,
    input  wire logic       i_playback_need,
    input  wire logic       i_capture_avail,
    input  wire logic       i_fifo_drained,
    input  wire logic       i_overrun,
    input  wire logic       i_underrun,
    input  wire logic [2:0] i_capture_track,
    input  wire logic [2:0] i_playback_track,
    input  wire logic [7:0] i_capture_byte,
    output logic      [7:0] o_playback_byte,
    output logic            o_playback_write,
    output logic            o_capture_read,
    // converter control and interrupt flag
    output logic            o_dac_mute_left,
    output logic            o_dac_mute_right,
    output logic            o_adc_midscale,
    output logic            o_dac_midscale,
    output logic            o_dac_repeat,
    output logic            o_capture_hold,
    output logic            o_interrupt_flag
);
    import codec_port_pkg::*;

    typedef struct packed {
        phase_t          phase;
        logic [15:0]     init_cnt;
        logic [6:0]      index;
        logic [31:0][7:0] regs;
        logic            int_flag;
        logic [15:0]     count;
        logic            pb_req;
        logic            cp_req;
        logic [5:0]      settle_cnt;
        logic [8:0]      cal_cnt;
        logic            sour;
        logic            cor;
        logic            pur;
        logic [7:0]      rd_data;
        logic [7:0]      pb_byte;
        logic            pb_wr;
        logic            cp_rd;
        logic [2:0]      rd_s;
        logic [2:0]      wr_s;
        logic [2:0]      pa_s;
        logic [2:0]      ca_s;
        logic            rd_f;
        logic            wr_f;
        logic            pa_f;
        logic            ca_f;
        logic [1:0]      sel_q;
        logic            cs_q;
        logic [7:0]      data_q;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // three-stage filter: accept only when stages two and three agree
    function automatic logic filt(input logic [2:0] s, input logic cur);
        filt = (s[1] == s[2]) ? s[1] : cur;
    endfunction

    // effective index, top bit dropped in legacy mode
    function automatic logic [4:0] eff_index(input logic [4:0] ix, input logic expanded_mode);
        eff_index = {ix[IDX_TOP_BIT] & expanded_mode, ix[3:0]};
    endfunction

    logic       initing;
    logic       mode_flag;
    logic       gate_bit;
    logic       gated;
    logic       rd_edge;
    logic       wr_edge;
    logic [4:0] win_ix;
    logic       playback_enable_bit;
    logic       capture_enable_bit;
    logic       expanded_mode;
    logic [7:0] status_byte;
    logic [7:0] win_byte;

    always_comb begin
        initing     = (st_r.phase == ST_INIT);
        mode_flag   = st_r.index[IDX_MODE_BIT];
        gate_bit    = st_r.index[IDX_GATE_BIT];
        gated       = gate_bit & st_r.int_flag;
        rd_edge     = st_r.rd_f & ~filt(st_r.rd_s, st_r.rd_f) & st_r.cs_q;
        wr_edge     = ~st_r.wr_f & filt(st_r.wr_s, st_r.wr_f) & st_r.cs_q;
        expanded_mode       = st_r.regs[REG_MISC][EXPANDED_MODE_BIT];
        win_ix      = eff_index(st_r.index[4:0], expanded_mode);
        playback_enable_bit         = st_r.regs[REG_IFACE][PEN_BIT];
        capture_enable_bit         = st_r.regs[REG_IFACE][CEN_BIT];
        status_byte = {i_capture_track, st_r.sour, i_playback_track, st_r.int_flag};
        win_byte    = st_r.regs[win_ix];
        if (win_ix == REG_ERRORS) begin
            win_byte[COR_BIT] = st_r.cor;
            win_byte[PUR_BIT] = st_r.pur;
            win_byte[ACI_BIT] = (st_r.cal_cnt != 9'h000);
        end
    end

    always_comb begin
        st_nxt        = st_r;
        st_nxt.pb_wr  = 1'b0;
        st_nxt.cp_rd  = 1'b0;
        // pin synchronisers
        st_nxt.rd_s   = {st_r.rd_s[1:0], i_rd_b};
        st_nxt.wr_s   = {st_r.wr_s[1:0], i_wr_b};
        st_nxt.pa_s   = {st_r.pa_s[1:0], i_playback_ack_b};
        st_nxt.ca_s   = {st_r.ca_s[1:0], i_capture_ack_b};
        st_nxt.rd_f   = filt(st_r.rd_s, st_r.rd_f);
        st_nxt.wr_f   = filt(st_r.wr_s, st_r.wr_f);
        st_nxt.pa_f   = filt(st_r.pa_s, st_r.pa_f);
        st_nxt.ca_f   = filt(st_r.ca_s, st_r.ca_f);
        // address and data are stable while a strobe is low
        st_nxt.sel_q  = i_direct_select_pins;
        st_nxt.cs_q   = ~i_cs_b;
        st_nxt.data_q = i_data;

        // host read: latch the addressed register
        if (rd_edge) begin
            unique case (st_r.sel_q)
                SEL_INDEX: begin
                    st_nxt.rd_data = initing ? INIT_READ : {1'b0, st_r.index};
                end
                SEL_WINDOW: begin
                    st_nxt.rd_data = initing ? INIT_READ : win_byte;
                end
                SEL_STATUS: begin
                    st_nxt.rd_data = status_byte;
                end
                SEL_PIO: begin
                    st_nxt.rd_data = initing ? INIT_READ : i_capture_byte;
                    st_nxt.cp_rd   = ~initing;
                end
            endcase
        end

        // host write: ignored while initializing
        if (wr_edge && !initing) begin
            unique case (st_r.sel_q)
                SEL_INDEX: begin
                    st_nxt.index = st_r.data_q[6:0];
                end
                SEL_WINDOW: begin
                    st_nxt.regs[win_ix] = st_r.data_q;
                end
                SEL_STATUS: begin
                    st_nxt.int_flag = 1'b0;
                end
                SEL_PIO: begin
                    st_nxt.pb_byte = st_r.data_q;
                    st_nxt.pb_wr   = 1'b1;
                end
            endcase
        end

        // dma current counter, underflow sets the sticky flag
        if (i_sample_moved && (playback_enable_bit || capture_enable_bit) && !gated) begin
            if (st_r.count == 16'h0000) begin
                st_nxt.count    = {st_r.regs[REG_UPPER_BASE], st_r.regs[REG_LOWER_BASE]};
                st_nxt.int_flag = 1'b1;
            end else begin
                st_nxt.count = st_r.count - 16'h0001;
            end
        end

        // requests: new ones only when not gated, pending ones complete
        if (st_r.pb_req) begin
            st_nxt.pb_req = ~(st_r.pa_f & ~filt(st_r.pa_s, st_r.pa_f));
        end else begin
            st_nxt.pb_req = playback_enable_bit & i_playback_need & ~gated & ~initing;
        end
        if (st_r.cp_req) begin
            st_nxt.cp_req = ~(st_r.ca_f & ~filt(st_r.ca_s, st_r.ca_f));
        end else begin
            st_nxt.cp_req = capture_enable_bit & i_capture_avail & ~gated & ~initing;
        end

        // error flags follow each sample, suppressed while gated
        if (i_sample_tick) begin
            st_nxt.cor  = i_overrun & ~gated;
            st_nxt.pur  = i_underrun & ~gated;
            st_nxt.sour = (i_overrun | i_underrun) & ~gated;
        end

        if (i_sample_tick && st_r.cal_cnt != 9'h000) begin
            st_nxt.cal_cnt = st_r.cal_cnt - 9'h001;
        end

        // phase sequencing
        unique case (st_r.phase)
            ST_INIT: begin
                st_nxt.init_cnt = st_r.init_cnt - 16'h0001;
                if (st_r.init_cnt == 16'h0000) begin
                    st_nxt.phase = ST_RUN;
                end
            end
            ST_RUN: begin
                if (mode_flag) begin
                    st_nxt.phase = ST_MODE;
                end
            end
            ST_MODE: begin
                if (!mode_flag) begin
                    st_nxt.phase      = ST_SETTLE;
                    st_nxt.settle_cnt = SETTLE_SAMPLES;
                    if (st_r.regs[REG_IFACE][AUTO_CALIBRATE_BIT_BIT]) begin
                        st_nxt.cal_cnt = CAL_SAMPLES;
                    end
                end
            end
            ST_SETTLE: begin
                if (mode_flag) begin
                    st_nxt.phase = ST_MODE;
                end else if (i_sample_tick) begin
                    st_nxt.settle_cnt = st_r.settle_cnt - 6'h01;
                    if (st_r.settle_cnt == 6'h01) begin
                        st_nxt.phase = ST_RUN;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r          <= '0;
            st_r.phase    <= ST_INIT;
            st_r.init_cnt <= INIT_LEN;
            st_r.index    <= INDEX_RESET[6:0];
            st_r.rd_s     <= 3'h7;
            st_r.wr_s     <= 3'h7;
            st_r.pa_s     <= 3'h7;
            st_r.ca_s     <= 3'h7;
            st_r.rd_f     <= 1'b1;
            st_r.wr_f     <= 1'b1;
            st_r.pa_f     <= 1'b1;
            st_r.ca_f     <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs
    always_comb begin
        o_data                 = st_r.rd_data;
        o_data_oe              = st_r.cs_q & ~st_r.rd_f;
        o_playback_request_out = st_r.pb_req;
        o_capture_request_out  = st_r.cp_req;
        o_playback_byte        = st_r.pb_byte;
        o_playback_write       = st_r.pb_wr;
        o_capture_read         = st_r.cp_rd;
        o_interrupt_flag       = st_r.int_flag;
        o_dac_mute_left        = mode_flag | (st_r.phase == ST_SETTLE)
                                 | st_r.regs[REG_LEFT_OUT][MUTE_BIT];
        o_dac_mute_right       = mode_flag | (st_r.phase == ST_SETTLE)
                                 | st_r.regs[REG_RIGHT_OUT][MUTE_BIT];
        o_adc_midscale         = (st_r.phase == ST_SETTLE);
        o_dac_midscale         = gated & i_fifo_drained & ~st_r.pb_req
                                 & st_r.regs[REG_FEATURE][ZERO_FILL_BIT];
        o_dac_repeat           = gated & i_fifo_drained & ~st_r.pb_req
                                 & ~st_r.regs[REG_FEATURE][ZERO_FILL_BIT];
        o_capture_hold         = gated & ~st_r.cp_req;
    end

    chk_init_reads_80: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        initing && rd_edge && st_r.sel_q != SEL_STATUS |=> st_r.rd_data == INIT_READ)
        else $error("read during init not 80h");

    chk_counter_holds: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        gated |=> st_r.count == $past(st_r.count))
        else $error("dma counter moved while gated");

    chk_status_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        wr_edge && !initing && st_r.sel_q == SEL_STATUS && !(i_sample_moved && (playback_enable_bit || capture_enable_bit))
        |=> !st_r.int_flag)
        else $error("status write did not clear interrupt");

    chk_no_err_gated: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_sample_tick && gated |=> !st_r.sour && !st_r.cor && !st_r.pur)
        else $error("error flagged while gated");

    chk_mode_mutes: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        mode_flag |-> o_dac_mute_left && o_dac_mute_right)
        else $error("dac not muted in mode change");

    chk_settle_span: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        st_r.phase == ST_MODE && !mode_flag
        |=> st_r.settle_cnt == SETTLE_SAMPLES && o_adc_midscale)
        else $error("settle period not started at 32");

    chk_cal_needs_auto_calibrate_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        st_r.phase == ST_MODE && !mode_flag
        |=> (st_r.cal_cnt == CAL_SAMPLES) == $past(st_r.regs[REG_IFACE][AUTO_CALIBRATE_BIT_BIT]))
        else $error("calibration busy mismatch");

    chk_legacy_index: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !expanded_mode |-> win_ix == {1'b0, st_r.index[3:0]})
        else $error("top index bit used in legacy mode");

    chk_req_gated: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !st_r.pb_req && gated |=> !st_r.pb_req)
        else $error("new playback request while gated");

    chk_index_store: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        wr_edge && !initing && st_r.sel_q == SEL_INDEX
        |=> st_r.index == $past(st_r.data_q[6:0]))
        else $error("index write not stored");

    chk_cap_gated: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !st_r.cp_req && gated |=> !st_r.cp_req)
        else $error("new capture request while gated");

    chk_req_resume: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !gated && !initing && playback_enable_bit && i_playback_need && !st_r.pb_req |=> st_r.pb_req)
        else $error("playback request not resumed");

    chk_drain_choice: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        gated && i_fifo_drained && !st_r.pb_req |-> o_dac_midscale != o_dac_repeat)
        else $error("drained dac source not chosen");

    chk_init_frozen: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        initing |=> st_r.index == $past(st_r.index) && st_r.regs == $past(st_r.regs))
        else $error("register changed during init");
endmodule

//--- sim/host_bus_model.sv
// host bus model for the direct register port
module host_bus_model (
    // clock
    input  wire logic       i_clk,
    // read data from the port
    input  wire logic [7:0] i_data,
    // host bus pins
    output logic      [1:0] o_sel,
    output logic            o_cs_b,
    output logic            o_rd_b,
    output logic            o_wr_b,
    output logic      [7:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import codec_port_pkg::*;
    logic expanded = 1'b0;
    initial begin
        o_sel  = SEL_STATUS;
        o_cs_b = 1'b1;
        o_rd_b = 1'b1;
        o_wr_b = 1'b1;
        o_data = 8'h00;
    end
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        @(negedge i_clk);
        o_sel  = sel;
        o_cs_b = 1'b0;
        o_data = (sel == SEL_INDEX && !expanded) ? (d & 8'hef) : d;
        o_wr_b = 1'b0;
        repeat (5) @(negedge i_clk);
        o_wr_b = 1'b1;
        repeat (5) @(negedge i_clk);
        o_cs_b = 1'b1;
        o_data = ~o_data;
    endtask
    task automatic rd(input logic [1:0] sel, output logic [7:0] d);
        @(negedge i_clk);
        o_sel  = sel;
        o_cs_b = 1'b0;
        o_rd_b = 1'b0;
        repeat (6) @(negedge i_clk);
        d      = i_data;
        o_rd_b = 1'b1;
        repeat (5) @(negedge i_clk);
        o_cs_b = 1'b1;
    endtask
endmodule

//--- sim/tb_top.sv
// testbench for the codec direct register port
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import codec_port_pkg::*;
    logic       clk = 1'b0, rst_b = 1'b0, pb_ack_b = 1'b1, cp_ack_b = 1'b1;
    logic       tick_p = 1'b0, moved = 1'b0, need = 1'b0, avail = 1'b0;
    logic       drained = 1'b0, ovr = 1'b0, udr = 1'b0;
    logic [2:0] ctrack = 3'h5, ptrack = 3'h2;
    logic [7:0] cbyte = 8'h3c;
    logic [1:0] sel;
    logic       cs_b, rd_b, wr_b, pb_req, cp_req, mute_l, mute_r, irq;
    logic       adc_mid, dac_mid, dac_rep, cap_hold;
    logic       oe, pb_wr, cp_rd;
    logic [7:0] oe_n = 8'h00, pw_n = 8'h00, cr_n = 8'h00;
    logic [7:0] hdata, pdata, pb_byte;
    logic [7:0] iw[3] = '{8'h2f, 8'h4a, 8'h8e};
    logic [7:0] ie[3] = '{8'h2f, 8'h4a, 8'h0e};
    int         miscompares = 0;
    int         check_count = 0;
    always #2 clk = ~clk;
    // count cycles of read enable and strobe pulses
    always @(negedge clk) begin
        if (oe) oe_n <= oe_n + 8'h01;
        if (pb_wr) pw_n <= pw_n + 8'h01;
        if (cp_rd) cr_n <= cr_n + 8'h01;
    end
    host_bus_model host (.i_clk(clk), .i_data(pdata), .o_sel(sel), .o_cs_b(cs_b),
        .o_rd_b(rd_b), .o_wr_b(wr_b), .o_data(hdata));
    codec_direct_register_port #(.INIT_LEN(16'd100)) dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_direct_select_pins(sel), .i_cs_b(cs_b),
        .i_rd_b(rd_b), .i_wr_b(wr_b), .i_data(hdata), .o_data(pdata), .o_data_oe(oe),
        .o_playback_request_out(pb_req), .o_capture_request_out(cp_req),
        .i_playback_ack_b(pb_ack_b), .i_capture_ack_b(cp_ack_b),
        .i_sample_tick(tick_p), .i_sample_moved(moved), .i_playback_need(need),
        .i_capture_avail(avail), .i_fifo_drained(drained), .i_overrun(ovr),
        .i_underrun(udr), .i_capture_track(ctrack), .i_playback_track(ptrack),
        .i_capture_byte(cbyte), .o_playback_byte(pb_byte), .o_playback_write(pb_wr),
        .o_capture_read(cp_rd), .o_dac_mute_left(mute_l), .o_dac_mute_right(mute_r),
        .o_adc_midscale(adc_mid), .o_dac_midscale(dac_mid), .o_dac_repeat(dac_rep),
        .o_capture_hold(cap_hold), .o_interrupt_flag(irq));
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic rchk(input logic [1:0] s, input logic [7:0] exp, input string what);
        logic [7:0] v;
        host.rd(s, v);
        chk(v, exp, what);
    endtask
    task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
        host.wr(SEL_INDEX, idx);
        host.wr(SEL_WINDOW, v);
    endtask
    task automatic pulse(input bit mv, input int n);
        repeat (n) begin
            @(negedge clk);
            if (mv) moved = 1'b1;
            else tick_p = 1'b1;
            @(negedge clk);
            moved  = 1'b0;
            tick_p = 1'b0;
        end
    endtask
    task automatic ack();
        @(negedge clk);
        pb_ack_b = 1'b0;
        repeat (4) @(negedge clk);
        pb_ack_b = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("watchdog expired");
        close_out();
    end
    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        rchk(SEL_INDEX, INIT_READ, "init index");
        chk(oe_n, 8'h06, "read enable span");
        host.wr(SEL_INDEX, 8'h05);
        rchk(SEL_INDEX, INIT_READ, "init index after write");
        rchk(SEL_WINDOW, INIT_READ, "init window");
        host.wr(SEL_PIO, 8'h77);
        rchk(SEL_PIO, INIT_READ, "init pio");
        chk(pb_byte, 8'h00, "init pio write");
        chk({pw_n[3:0], cr_n[3:0]}, 8'h00, "init pio strobes");
        repeat (60) @(negedge clk);
        rchk(SEL_INDEX, INDEX_RESET, "index after init");
        $display("test init done");
        for (int i = 0; i < 3; i++) begin
            host.wr(SEL_INDEX, iw[i]);
            rchk(SEL_INDEX, ie[i], "index readback");
        end
        pulse(1'b0, 32);
        wreg(8'h00, 8'h5a);
        wreg(8'h06, 8'h80);
        rchk(SEL_WINDOW, 8'h80, "window reg6");
        host.wr(SEL_INDEX, 8'h00);
        rchk(SEL_WINDOW, 8'h5a, "window reg0");
        chk({6'h0, mute_l, mute_r}, 8'h02, "mute bits");
        host.wr(SEL_PIO, 8'ha5);
        chk(pb_byte, 8'ha5, "pio write");
        chk(pw_n, 8'h01, "pio write strobe");
        rchk(SEL_PIO, 8'h3c, "pio read");
        chk(cr_n, 8'h01, "pio read strobe");
        rchk(SEL_STATUS, 8'ha4, "status");
        $display("test registers done");
        wreg(8'h0e, 8'h00);
        wreg(8'h0f, 8'h01);
        wreg(8'h49, 8'h09);
        chk({7'h0, mute_r}, 8'h01, "mode mute");
        host.wr(SEL_INDEX, 8'h09);
        chk({6'h0, adc_mid, mute_r}, 8'h03, "settle start");
        wreg(8'h0b, 8'h00);
        rchk(SEL_WINDOW, 8'h20, "cal busy set");
        pulse(1'b0, 31);
        chk({7'h0, adc_mid}, 8'h01, "settle 31");
        pulse(1'b0, 1);
        chk({6'h0, adc_mid, mute_r}, 8'h00, "settle 32");
        pulse(1'b0, 351);
        rchk(SEL_WINDOW, 8'h20, "cal busy 383");
        pulse(1'b0, 1);
        rchk(SEL_WINDOW, 8'h00, "cal busy 384");
        $display("test mode change done");
        need  = 1'b1;
        avail = 1'b1;
        repeat (2) @(negedge clk);
        chk({6'h0, pb_req, cp_req}, 8'h02, "request");
        ack();
        for (int i = 0; i < 4 && irq !== 1'b1; i++) pulse(1'b1, 1);
        chk({7'h0, irq}, 8'h01, "counter underflow");
        ack();
        chk({7'h0, pb_req}, 8'h01, "request with interrupt");
        host.wr(SEL_INDEX, 8'h2b);
        chk({7'h0, pb_req}, 8'h01, "outstanding request");
        ack();
        chk({7'h0, pb_req}, 8'h00, "gated request");
        drained = 1'b1;
        repeat (2) @(negedge clk);
        chk({5'h0, dac_rep, dac_mid, cap_hold}, 8'h05, "drained outputs");
        wreg(8'h2c, 8'h40);
        host.expanded = 1'b1;
        wreg(8'h30, 8'h01);
        chk({5'h0, dac_rep, dac_mid, cap_hold}, 8'h03, "drained midscale");
        rchk(SEL_WINDOW, 8'h01, "expanded index");
        host.wr(SEL_INDEX, 8'h2b);
        udr = 1'b1;
        pulse(1'b0, 1);
        udr = 1'b0;
        rchk(SEL_WINDOW, 8'h00, "no underrun");
        rchk(SEL_STATUS, 8'ha5, "status gated");
        pulse(1'b1, 3);
        pulse(1'b0, 2);
        chk({7'h0, irq}, 8'h01, "sticky");
        host.wr(SEL_STATUS, 8'h00);
        chk({6'h0, irq, pb_req}, 8'h01, "clear resumes");
        pulse(1'b1, 1);
        chk({7'h0, irq}, 8'h00, "counter held");
        pulse(1'b1, 1);
        chk({7'h0, irq}, 8'h01, "counter after hold");
        $display("test gating done");
        close_out();
    end
endmodule
